/* src/bsa_regs.svh */
`ifndef BSA_REGS_SVH
`define BSA_REGS_SVH
// default lane count and its legal range
`define BSA_LANES_DEF 8
`define BSA_LANES_MIN 2
`define BSA_LANES_MAX 32
// default operand word width handled by the serialiser
`define BSA_WORD_DEF 8
// default depth of the word fifo
`define BSA_FIFO_DEPTH 16
`endif

/* src/bsa_pkg.sv */
package bsa_pkg;
  typedef enum logic [1:0] {
    BSA_IDLE,
    BSA_SHIFT,
    BSA_EXTEND
  } bsa_state_t;
endpackage

/* src/bsa_if.sv */
`timescale 1ns/1ps
interface bsa_if #(
  parameter int LANES = 8
) (
  input wire logic CLK
);
  logic [LANES-1:0] a_bit;
  logic [LANES-1:0] b_bit;
  logic carry_clear;
  logic enable;
  logic [LANES-1:0] serial_sum_out;

  modport adder (
    input a_bit,
    input b_bit,
    input carry_clear,
    input enable,
    output serial_sum_out
  );
  modport driver (
    output a_bit,
    output b_bit,
    output carry_clear,
    output enable,
    input serial_sum_out
  );
endinterface

/* src/bsa_fifo.sv */
`timescale 1ns/1ps
module bsa_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_q];

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset so it maps onto plain ram
  always_ff @(posedge CLK) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
endmodule

/* src/bsa_adder.sv */
`timescale 1ns/1ps
`include "bsa_regs.svh"
// How it works
// RULE1: two to thirty-two lanes, one bit pair each
// RULE2: every lane has its own sum and carry
// RULE3: sum of a, b and stored carry
// RULE4: carry clear treats incoming carry as zero
// RULE5: sum output changes only when enabled
// RULE6: driver sends words lsb first, one bit/clock
// RULE7: driver raises carry clear on lsb clock
// RULE8: n-bit words take n+1 enabled clocks
// RULE9: driver repeats msb in extra cycle for signed words, sends zero for unsigned
// RULE10: all state updates on rising clock edge
// RULE11: carry held while enable is low
module bsa_adder
  import bsa_pkg::*;
#(
  parameter int LANES = `BSA_LANES_DEF
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // serial operand side
  bsa_if.adder LINK
);
  // ************************************************
  // lane range check
  // ************************************************
  // refuse to build rather than quietly produce an unsupported lane count
  if (LANES < `BSA_LANES_MIN || LANES > `BSA_LANES_MAX) begin : g_bad_lanes // RULE1
    $error("lane count out of range");
  end

  // ************************************************
  // per-lane full adders
  // ************************************************
  logic [LANES-1:0] serial_sum_q, serial_sum_d;
  logic [LANES-1:0] stored_carry_q, stored_carry_d;
  logic [LANES-1:0] carry_in;

  always_comb begin
    serial_sum_d = serial_sum_q;
    stored_carry_d = stored_carry_q;
    carry_in = LINK.carry_clear ? '0 : stored_carry_q; // RULE4
    if (LINK.enable) begin // RULE5 RULE11
      // bitwise vectors keep each lane apart from its neighbours
      serial_sum_d = LINK.a_bit ^ LINK.b_bit ^ carry_in; // RULE1 RULE2 RULE3
      stored_carry_d = (LINK.a_bit & LINK.b_bit) | (carry_in & (LINK.a_bit ^ LINK.b_bit)); // RULE3
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin // RULE10
    if (!RESET_N) begin
      serial_sum_q <= '0;
      stored_carry_q <= '0;
    end else begin
      serial_sum_q <= serial_sum_d;
      stored_carry_q <= stored_carry_d;
    end
  end

  assign LINK.serial_sum_out = serial_sum_q;
endmodule

/* src/bsa_driver.sv */
`timescale 1ns/1ps
`include "bsa_regs.svh"
module bsa_driver
  import bsa_pkg::*;
#(
  parameter int LANES = `BSA_LANES_DEF,
  parameter int WORD = `BSA_WORD_DEF,
  parameter int DEPTH = `BSA_FIFO_DEPTH
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // parallel word pairs in
  input wire logic [LANES*WORD-1:0] OP_A,
  input wire logic [LANES*WORD-1:0] OP_B,
  input wire logic OP_SIGNED,
  input wire logic OP_VALID,
  output logic OP_READY,
  // parallel results out
  output logic [LANES*(WORD+1)-1:0] SUM,
  output logic SUM_VALID,
  // pause for the serial link
  input wire logic HOLD,
  // serial link
  bsa_if.driver LINK
);
  localparam int FW = 2*LANES*WORD + 1;
  localparam int CW = $clog2(WORD+2);

  logic [FW-1:0] f_data;
  logic f_valid, f_take;

  bsa_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .in_data({OP_SIGNED, OP_A, OP_B}),
    .in_valid(OP_VALID),
    .in_ready(OP_READY),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_take)
  );

  // ************************************************
  // serialiser
  // ************************************************
  bsa_state_t st_q, st_d;
  logic [CW-1:0] bit_q, bit_d;
  logic [LANES*WORD-1:0] a_q, a_d, b_q, b_d;
  logic sgn_q, sgn_d;
  logic [LANES-1:0] a_now, b_now;
  logic step;

  assign step = !HOLD;
  assign f_take = (st_q == BSA_IDLE) && step;

  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      // unsigned words extend with zero in the extra cycle
      a_now[l] = (st_q == BSA_EXTEND && !sgn_q) ? 1'b0 : a_q[l*WORD + int'(bit_q)];
      b_now[l] = (st_q == BSA_EXTEND && !sgn_q) ? 1'b0 : b_q[l*WORD + int'(bit_q)];
    end
  end

  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    a_d = a_q;
    b_d = b_q;
    sgn_d = sgn_q;
    case (st_q)
      BSA_IDLE: begin
        if (f_valid && step) begin
          {sgn_d, a_d, b_d} = f_data;
          bit_d = '0;
          st_d = BSA_SHIFT;
        end
      end
      BSA_SHIFT: begin
        if (step) begin
          if (bit_q == CW'(WORD-1)) begin
            st_d = BSA_EXTEND; // RULE9
          end else begin
            bit_d = bit_q + 1'b1; // RULE6
          end
        end
      end
      BSA_EXTEND: begin
        if (step) begin
          st_d = BSA_IDLE; // RULE8
        end
      end
      default: st_d = BSA_IDLE;
    endcase
  end

  assign LINK.a_bit = a_now;
  assign LINK.b_bit = b_now;
  assign LINK.enable = step && (st_q != BSA_IDLE);
  assign LINK.carry_clear = (st_q == BSA_SHIFT) && (bit_q == '0); // RULE7

  // ************************************************
  // result collection, one clock behind the link
  // ************************************************
  logic [CW-1:0] got_q, got_d;
  logic [LANES*(WORD+1)-1:0] sum_q, sum_d;
  logic coll_q, coll_d, sv_q, sv_d;

  always_comb begin
    got_d = got_q;
    sum_d = sum_q;
    sv_d = 1'b0;
    coll_d = LINK.enable;
    if (coll_q) begin
      for (int l = 0; l < LANES; l++) begin
        sum_d[l*(WORD+1) + int'(got_q)] = LINK.serial_sum_out[l];
      end
      if (got_q == CW'(WORD)) begin
        got_d = '0;
        sv_d = 1'b1;
      end else begin
        got_d = got_q + 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q <= BSA_IDLE;
      bit_q <= '0;
      a_q <= '0;
      b_q <= '0;
      sgn_q <= 1'b0;
      got_q <= '0;
      sum_q <= '0;
      coll_q <= 1'b0;
      sv_q <= 1'b0;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      a_q <= a_d;
      b_q <= b_d;
      sgn_q <= sgn_d;
      got_q <= got_d;
      sum_q <= sum_d;
      coll_q <= coll_d;
      sv_q <= sv_d;
    end
  end

  assign SUM = sum_q;
  assign SUM_VALID = sv_q;
endmodule

/* verification/bsa_adder_sva.sv */
`timescale 1ns/1ps
module bsa_adder_sva #(
  parameter int LANES = 8,
  parameter int WORD = 8
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // serial link
  input wire logic [LANES-1:0] a_bit,
  input wire logic [LANES-1:0] b_bit,
  input wire logic carry_clear,
  input wire logic enable,
  input wire logic [LANES-1:0] serial_sum_out
);
  // ****************
  // shadow state
  // ****************
  logic [LANES-1:0] c_q, c_d, a_q, a_d;
  logic [7:0] n_q, n_d;
  always_comb begin
    c_d = c_q;
    a_d = a_q;
    n_d = n_q;
    if (enable) begin
      c_d = (a_bit & b_bit) | ((a_bit ^ b_bit) & c_q & {LANES{!carry_clear}});
      a_d = a_bit;
      n_d = carry_clear ? 8'h01 : n_q + 8'h01;
    end
  end
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      c_q <= '0;
      a_q <= '0;
      n_q <= '0;
    end else begin
      c_q <= c_d;
      a_q <= a_d;
      n_q <= n_d;
    end
  end
  // ****************
  // properties
  // ****************
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sum_add_a: assert property (enable && !carry_clear |=>
    serial_sum_out == $past(a_bit ^ b_bit ^ c_q)) else $error("sum with carry");
  clr_add_a: assert property (enable && carry_clear |=>
    serial_sum_out == $past(a_bit ^ b_bit)) else $error("sum after clear");
  hold_sum_a: assert property (!enable |=> $stable(serial_sum_out))
    else $error("sum moved");
  pause_carry_a: assert property (!enable ##1 (enable && !carry_clear) |=>
    serial_sum_out == $past(a_bit ^ b_bit ^ c_q)) else $error("carry lost");
  word_len_a: assert property (enable && carry_clear && n_q != 0 |->
    n_q == WORD + 1) else $error("word length");
  len_max_a: assert property (n_q <= WORD + 1) else $error("word too long");
  first_clr_a: assert property (enable && n_q == 0 |-> carry_clear)
    else $error("no clear");
  ext_bit_a: assert property (enable && n_q == WORD |-> (a_bit & ~a_q) == '0)
    else $error("bad extension");
endmodule

/* verification/test_bit_serial_multi_lane_adder.sv */
`timescale 1ns/1ps
module test_bit_serial_multi_lane_adder;
  localparam int LANES = 4;
  localparam int WORD = 8;
  localparam int SW = LANES * (WORD + 1);
  logic CLK = 0;
  logic RESET_N = 0;
  logic [LANES*WORD-1:0] OP_A = '0;
  logic [LANES*WORD-1:0] OP_B = '0;
  logic OP_SIGNED = 0;
  logic OP_VALID = 0;
  logic OP_READY;
  logic [SW-1:0] SUM;
  logic SUM_VALID;
  logic HOLD = 1;
  logic seen_full = 0;
  logic [SW-1:0] exp_q[$];
  int n_fail = 0;
  int checked = 0;
  int t;
  bsa_if #(.LANES(LANES)) i_bsa_if (.CLK(CLK));
  bsa_driver #(.LANES(LANES), .WORD(WORD), .DEPTH(16)) i_bsa_driver (.CLK(CLK),
    .RESET_N(RESET_N), .OP_A(OP_A), .OP_B(OP_B), .OP_SIGNED(OP_SIGNED), .OP_VALID(OP_VALID),
    .OP_READY(OP_READY), .SUM(SUM), .SUM_VALID(SUM_VALID), .HOLD(HOLD), .LINK(i_bsa_if.driver));
  bsa_adder #(.LANES(LANES)) i_bsa_adder (.CLK(CLK), .RESET_N(RESET_N), .LINK(i_bsa_if.adder));
  bsa_adder_sva #(.LANES(LANES), .WORD(WORD)) i_bsa_adder_sva (.CLK(CLK), .RESET_N(RESET_N),
    .a_bit(i_bsa_if.a_bit), .b_bit(i_bsa_if.b_bit), .carry_clear(i_bsa_if.carry_clear),
    .enable(i_bsa_if.enable), .serial_sum_out(i_bsa_if.serial_sum_out));
  initial forever #12.5 CLK = ~CLK;
  // the link stalls for the first 200 cycles so the fifo fills, then pauses at random
  always @(negedge CLK) HOLD <= ($time < 5000) | ($urandom_range(3) == 0);
  task check(input logic [SW-1:0] seen, input logic [SW-1:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function logic [SW-1:0] model(input logic [LANES*WORD-1:0] a, b, input logic sg);
    logic [SW-1:0] r;
    for (int l = 0; l < LANES; l++) begin
      r[l*(WORD+1)+:WORD+1] = {sg & a[l*WORD+WORD-1], a[l*WORD+:WORD]}
        + {sg & b[l*WORD+WORD-1], b[l*WORD+:WORD]};
    end
    return r;
  endfunction
  task push(input logic [LANES*WORD-1:0] a, b, input logic sg);
    @(negedge CLK);
    OP_A = a;
    OP_B = b;
    OP_SIGNED = sg;
    OP_VALID = 1;
    t = 0;
    while (OP_READY !== 1'b1) begin
      seen_full = 1;
      @(negedge CLK);
      if (++t > 500) begin
        n_fail++;
        summarize();
      end
    end
    @(posedge CLK);
    exp_q.push_back(model(a, b, sg));
  endtask
  always @(negedge CLK) begin
    if (SUM_VALID === 1'b1) begin
      if (exp_q.size() == 0) check(SUM, ~SUM);
      else check(SUM, exp_q.pop_front());
    end
  end
  initial begin
    void'($urandom(32'hfa3f30cd));
    repeat (4) @(posedge CLK);
    @(negedge CLK) RESET_N = 1;
    push('1, '1, 1'b0);
    push('1, '1, 1'b1);
    push(32'h807f_0180, 32'h80ff_7f80, 1'b1);
    for (int i = 0; i < 60; i++) push($urandom, $urandom, 1'($urandom));
    @(negedge CLK) OP_VALID = 0;
    t = 0;
    while (exp_q.size() > 0 && t < 4000) begin
      @(negedge CLK);
      t++;
    end
    check(SW'(exp_q.size()), '0);
    check(SW'(seen_full), SW'(1));
    summarize();
  end
endmodule
